//--- scrs_core.sv
// Start-up configuration loader and reference input selector.
// Assumes strap and select pins are synchronous-ish levels from the board,
// stored configurations come from a one-time memory image on a port.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "scrs_defines.svh"

module scrs_core
    import scrs_pkg::*;
(
    input wire logic clk_in, // Core clock
    input wire logic sys_rst_in, // Power-on reset, sync, high
    input wire logic mode_strap_pin_in, // Mode strap
    input wire logic config_select_bit0_in, // Config select bit 0
    input wire logic config_select_bit1_in, // Config select bit 1
    input wire logic input_clock_select_pin_in, // Reference select
    input wire logic [`SCRS_CFG_W*`SCRS_CFG_DEPTH-1:0] otp_image_in, // Stored
    input wire scrs_bus_req_t bus_in, // Register port request
    input wire logic xtal_stopped_in, // Crystal gate has closed
    input wire logic differential_ref_input_stopped_in, // Differential gate has closed
    output scrs_ref_en_t ref_en_out, // Reference gate enables
    output logic [`SCRS_XTAL_W-1:0] crystal_load_trim_out, // Cap trim code
    output logic [`SCRS_CFG_W-1:0] active_config_out, // Loaded config
    output logic [1:0] config_index_out, // Loaded config index
    output logic hw_mode_out, // High in hardware select mode
    output logic config_busy_out, // Load or settle in progress
    output logic [7:0] rdata_out // Read data, cycle after strobe
);

    localparam logic [`SCRS_CNT_W-1:0] SETTLE_CYC =
        `SCRS_CNT_W'(`SCRS_SETTLE_CYC);
    localparam logic [23:0] HOLD_CYC = 24'(`SCRS_HOLD_CYC);

    scrs_state_reg_t r;
    scrs_state_reg_t next_r;

    // Picks one stored configuration from the flat image
    function automatic logic [`SCRS_CFG_W-1:0] cfg_pick(
        input logic [`SCRS_CFG_W*`SCRS_CFG_DEPTH-1:0] img,
        input logic [1:0] idx);
        cfg_pick = img[idx*`SCRS_CFG_W +: `SCRS_CFG_W];
    endfunction

    function automatic logic hit(input logic [`SCRS_ADDR_W-1:0] a,
                                 input logic [`SCRS_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic [`SCRS_CFG_W-1:0] cfg_word [`SCRS_CFG_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < `SCRS_CFG_DEPTH; gi++) begin : g_cfg
            assign cfg_word[gi] = cfg_pick(otp_image_in, 2'(gi));
        end
    endgenerate

    always_comb begin
        logic [7:0] rd;
        logic pin_differential_ref_input;
        logic manual;
        rd = 8'h00;
        pin_differential_ref_input = 1'b0;
        manual = 1'b0;
        next_r = r;
        // Two-stage synchronisers; first stage feeds only the second
        next_r.sel_meta = {config_select_bit1_in, config_select_bit0_in};
        next_r.sel_sync = r.sel_meta;
        next_r.csel_meta = input_clock_select_pin_in;
        next_r.csel_sync = r.csel_meta;

        if (!r.hold_done) begin
            next_r.hold_cnt = r.hold_cnt + 24'h000001;
            if (r.hold_cnt == HOLD_CYC - 24'h000001) begin
                next_r.hold_done = 1'b1;
            end
        end

        unique case (r.state)
            SCRS_ST_BOOT: begin
                next_r.hw_mode = mode_strap_pin_in;
                next_r.state = SCRS_ST_LOAD;
                next_r.sel_seen = {config_select_bit1_in,
                                   config_select_bit0_in};
                next_r.busy = 1'b1;
            end
            SCRS_ST_LOAD: begin
                if (r.hw_mode) begin
                    next_r.cfg_idx = r.sel_seen;
                    next_r.active_cfg = cfg_word[r.sel_seen];
                end else begin
                    next_r.cfg_idx = 2'b00;
                    next_r.active_cfg = cfg_word[0];
                end
                next_r.settle_cnt = SETTLE_CYC;
                next_r.state = SCRS_ST_RUN;
            end
            SCRS_ST_RUN: begin
                if (r.settle_cnt != '0) begin
                    next_r.settle_cnt = r.settle_cnt - `SCRS_CNT_W'(1);
                end else begin
                    next_r.busy = 1'b0;
                end
                // Changes before the hold window ends are acted on once it ends; the
                // board is not supposed to make them
                if (r.hw_mode && r.hold_done && !r.busy &&
                    r.sel_sync != r.sel_seen) begin
                    next_r.sel_seen = r.sel_sync;
                    next_r.busy = 1'b1;
                    next_r.state = SCRS_ST_LOAD;
                end
            end
            default: begin
                next_r.state = SCRS_ST_BOOT;
            end
        endcase

        // Register writes
        if (bus_in.wr) begin
            if (r.hw_mode) begin
                next_r.deny_seen = 1'b1;
            end else begin
                if (hit(bus_in.addr, `SCRS_REG_REFSEL)) begin
                    next_r.swap = bus_in.wdata[`SCRS_REFSEL_SWAP_BIT];
                end
                if (hit(bus_in.addr, `SCRS_REG_SWITCH)) begin
                    next_r.sm = bus_in.wdata[`SCRS_SWITCH_SM_LSB +: 2];
                end
                if (hit(bus_in.addr, `SCRS_REG_XTAL)) begin
                    next_r.xtal = bus_in.wdata[`SCRS_XTAL_W-1:0];
                end
                if (hit(bus_in.addr, `SCRS_REG_MODE)) begin
                    next_r.deny_seen = 1'b0;
                end
            end
        end

        // Register reads
        if (bus_in.rd) begin
            if (hit(bus_in.addr, `SCRS_REG_MODE)) begin
                rd = {6'h00, r.deny_seen, r.hw_mode};
            end else if (hit(bus_in.addr, `SCRS_REG_STATUS)) begin
                rd = {1'b0, r.hold_done, r.on_differential_ref_input, r.want_differential_ref_input,
                      r.busy, 1'b0, r.cfg_idx};
            end else if (hit(bus_in.addr, `SCRS_REG_REFSEL)) begin
                rd = {6'h00, r.swap, 1'b0};
            end else if (hit(bus_in.addr, `SCRS_REG_SWITCH)) begin
                rd = {6'h00, r.sm};
            end else if (hit(bus_in.addr, `SCRS_REG_XTAL)) begin
                rd = {2'b00, r.xtal};
            end else if (bus_in.addr >= `SCRS_REG_CFG_BASE &&
                         bus_in.addr < `SCRS_REG_CFG_BASE +
                         `SCRS_ADDR_W'(`SCRS_CFG_DEPTH * 4)) begin
                rd = cfg_word[bus_in.addr[3:2]];
            end
        end
        next_r.rdata = rd;

        // Manual switchover: pin xor swap picks the source
        manual = ~r.sm[1];
        pin_differential_ref_input = r.csel_sync ^ r.swap;
        if (manual) begin
            next_r.want_differential_ref_input = pin_differential_ref_input;
        end
        // Break before make: drop the old gate, wait for it to stop
        if (r.want_differential_ref_input != r.on_differential_ref_input) begin
            if (r.want_differential_ref_input ? xtal_stopped_in : differential_ref_input_stopped_in) begin
                next_r.on_differential_ref_input = r.want_differential_ref_input;
            end
        end

        if (sys_rst_in) begin
            next_r = '0;
            next_r.state = SCRS_ST_BOOT;
            next_r.swap = 1'(`SCRS_REFSEL_RST >> `SCRS_REFSEL_SWAP_BIT);
            next_r.sm = 2'(`SCRS_SWITCH_RST);
            next_r.xtal = `SCRS_XTAL_RST;
        end
    end

    always_ff @(posedge clk_in) begin
        r <= next_r;
    end

    // Gate open only when selection settled and the other gate is stopped
    always_comb begin
        ref_en_out.xtal_sel = !r.on_differential_ref_input && !r.want_differential_ref_input;
        ref_en_out.differential_ref_input_sel = r.on_differential_ref_input && r.want_differential_ref_input;
    end

    assign crystal_load_trim_out = r.xtal;
    assign active_config_out = r.active_cfg;
    assign config_index_out = r.cfg_idx;
    assign hw_mode_out = r.hw_mode;
    assign config_busy_out = r.busy;
    assign rdata_out = r.rdata;

endmodule

//--- scrs_core_monitor.sv
// Port checker for the start-up loader and reference select block.
// Assumes it is bound onto scrs_core and sees only that module's ports.
`timescale 1ns/1ps
module scrs_core_monitor
    import scrs_pkg::*;
(
    input wire logic clk_in, // Core clock
    input wire logic sys_rst_in, // Sync reset, high
    input wire scrs_bus_req_t bus_in, // Register port request
    input wire logic xtal_stopped_in, // Crystal gate closed
    input wire logic differential_ref_input_stopped_in, // Differential gate closed
    input wire scrs_ref_en_t ref_en_out, // Gate enables
    input wire logic [5:0] crystal_load_trim_out, // Trim code
    input wire logic [1:0] config_index_out, // Loaded index
    input wire logic hw_mode_out, // Hardware select mode
    input wire logic config_busy_out, // Load in progress
    input wire logic [7:0] rdata_out // Read data
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    rdata_idle_a: assert property (
        !$past(bus_in.rd) |-> rdata_out == 8'h00)
        else $error("read data outside its slot");
    gates_apart_a: assert property (
        !(ref_en_out.xtal_sel && ref_en_out.differential_ref_input_sel))
        else $error("both reference gates open");
    differential_ref_input_make_a: assert property (
        $rose(ref_en_out.differential_ref_input_sel) |-> $past(xtal_stopped_in))
        else $error("differential gate opened before crystal stopped");
    xtal_make_a: assert property (
        $rose(ref_en_out.xtal_sel) |-> $past(differential_ref_input_stopped_in))
        else $error("crystal gate opened before differential stopped");
    mode_once_a: assert property (
        $changed(hw_mode_out) |-> $past(sys_rst_in, 2))
        else $error("mode changed after start-up");
    trim_locked_a: assert property (
        hw_mode_out && $past(hw_mode_out) && $past(bus_in.wr)
        |-> $stable(crystal_load_trim_out))
        else $error("trim written in hardware mode");
    trim_write_a: assert property (
        !hw_mode_out && bus_in.wr && bus_in.addr == 8'h18
        |=> crystal_load_trim_out == $past(bus_in.wdata[5:0]))
        else $error("trim write not applied");
    index_load_a: assert property (
        $changed(config_index_out) |-> config_busy_out)
        else $error("index changed outside a load");
endmodule

bind scrs_core scrs_core_monitor u_mon (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .bus_in(bus_in),
    .xtal_stopped_in(xtal_stopped_in),
    .differential_ref_input_stopped_in(differential_ref_input_stopped_in),
    .ref_en_out(ref_en_out),
    .crystal_load_trim_out(crystal_load_trim_out),
    .config_index_out(config_index_out),
    .hw_mode_out(hw_mode_out),
    .config_busy_out(config_busy_out),
    .rdata_out(rdata_out)
);

//--- scrs_defines.svh
// Constants of the start-up configuration and reference select block.
// Assumes a 100 MHz core clock; included by the package and the design.
`ifndef SCRS_DEFINES_SVH
`define SCRS_DEFINES_SVH

// Register port map (byte offsets)
`define SCRS_ADDR_W 8
`define SCRS_REG_MODE 8'h00
`define SCRS_REG_STATUS 8'h04
`define SCRS_REG_REFSEL 8'h13
`define SCRS_REG_SWITCH 8'h14
`define SCRS_REG_XTAL 8'h18
`define SCRS_REG_CFG_BASE 8'h20
`define SCRS_REG_CFG_STRIDE 8'h04

// Field positions
`define SCRS_REFSEL_SWAP_BIT 1
`define SCRS_SWITCH_SM_LSB 0
`define SCRS_XTAL_W 6

// Reset values and stored configuration sizes
`define SCRS_REFSEL_RST 8'h00
`define SCRS_SWITCH_RST 8'h00
`define SCRS_XTAL_RST 6'h00
`define SCRS_CFG_W 8
`define SCRS_CFG_DEPTH 4

// Timing
`define SCRS_CLK_MHZ 100
`define SCRS_HOLD_MS 10
`define SCRS_SETTLE_MS 1
`define SCRS_HOLD_CYC (`SCRS_HOLD_MS * 1000 * `SCRS_CLK_MHZ)
`define SCRS_SETTLE_CYC (`SCRS_SETTLE_MS * 1000 * `SCRS_CLK_MHZ)
`define SCRS_CNT_W 20

`endif

//--- scrs_gate_model.sv
// Model of the two reference clock gates beside the block.
// Assumes the gate enables come from scrs_core on the same clock.
`timescale 1ns/1ps
module scrs_gate_model
    import scrs_pkg::*;
(
    input wire logic clk_in, // Core clock
    input wire logic rst_in, // Sync reset, high
    input wire scrs_ref_en_t ref_en_in, // Gate enables
    output logic xtal_stopped_out, // Crystal gate closed
    output logic differential_ref_input_stopped_out // Differential gate closed
);
    logic [1:0] stage;
    // Two cycles to close, so the block must really wait
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage <= 2'h1;
            {xtal_stopped_out, differential_ref_input_stopped_out} <= 2'h1;
        end else begin
            stage <= ~{ref_en_in.xtal_sel, ref_en_in.differential_ref_input_sel};
            {xtal_stopped_out, differential_ref_input_stopped_out} <= stage;
        end
    end
endmodule

//--- scrs_pkg.sv
// Types of the start-up configuration and reference select block.
// Assumes scrs_defines.svh is on the include path.
`include "scrs_defines.svh"

package scrs_pkg;

    typedef enum logic [1:0] {
        SCRS_ST_BOOT = 2'b00,
        SCRS_ST_LOAD = 2'b01,
        SCRS_ST_RUN = 2'b10
    } scrs_state_t;

    typedef struct packed {
        logic [`SCRS_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scrs_bus_req_t;

    typedef struct packed {
        logic xtal_sel;
        logic differential_ref_input_sel;
    } scrs_ref_en_t;

    typedef struct packed {
        scrs_state_t state;
        logic hw_mode;
        logic [1:0] sel_meta;
        logic [1:0] sel_sync;
        logic [1:0] sel_seen;
        logic [1:0] cfg_idx;
        logic csel_meta;
        logic csel_sync;
        logic want_differential_ref_input;
        logic on_differential_ref_input;
        logic [`SCRS_CNT_W-1:0] settle_cnt;
        logic [23:0] hold_cnt;
        logic hold_done;
        logic busy;
        logic deny_seen;
        logic swap;
        logic [1:0] sm;
        logic [`SCRS_XTAL_W-1:0] xtal;
        logic [7:0] rdata;
        logic [7:0] active_cfg;
    } scrs_state_reg_t;

endpackage

//--- startup_config_and_ref_select_tb_top.sv
// Testbench of the start-up loader and reference select block.
// Assumes scrs_core, its monitor and the gate model are compiled first.
`timescale 1ns/1ps
module startup_config_and_ref_select_tb_top
    import scrs_pkg::*;
;
    logic clk_in = 1'h0;
    logic rst = 1'h1;
    logic strap = 1'h0;
    logic [1:0] sel = 2'h0;
    logic pin = 1'h0;
    logic [31:0] otp;
    scrs_bus_req_t bus = '0;
    scrs_ref_en_t en;
    logic xs, cs, hw, busy;
    logic [5:0] trim;
    logic [7:0] act, got;
    logic [1:0] idx;
    int seed = 7;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 clk_in = ~clk_in;
    scrs_core uut (.clk_in(clk_in), .sys_rst_in(rst),
        .mode_strap_pin_in(strap), .config_select_bit0_in(sel[0]),
        .config_select_bit1_in(sel[1]), .input_clock_select_pin_in(pin),
        .otp_image_in(otp), .bus_in(bus), .xtal_stopped_in(xs),
        .differential_ref_input_stopped_in(cs), .ref_en_out(en),
        .crystal_load_trim_out(trim), .active_config_out(act),
        .config_index_out(idx), .hw_mode_out(hw),
        .config_busy_out(busy), .rdata_out(got));
    scrs_gate_model gates (.clk_in(clk_in), .rst_in(rst), .ref_en_in(en),
        .xtal_stopped_out(xs), .differential_ref_input_stopped_out(cs));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR %0t saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            test_done();
        end
    end
    // Pins stay still through reset and after it
    task automatic do_reset(input logic s, input logic [1:0] c);
        @(posedge clk_in);
        strap <= s;
        sel <= c;
        rst <= 1'h1;
        repeat (16) @(posedge clk_in);
        rst <= 1'h0;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk_in);
        bus <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge clk_in);
        bus <= '0;
        #1;
        chk(got, want);
    endtask
    function automatic logic [1:0] exp_en(input logic p, input logic sw);
        return (p ^ sw) ? 2'h1 : 2'h2;
    endfunction
    task automatic ref_chk(input logic p, input logic [1:0] want);
        @(posedge clk_in);
        pin <= p;
        repeat (12) @(posedge clk_in);
        #1;
        chk(8'(en), 8'(want));
    endtask
    logic [7:0] d;
    logic [7:0] regs [3] = '{8'h13, 8'h14, 8'h18};
    logic [7:0] msk [3] = '{8'h02, 8'h03, 8'h3F};
    initial begin
        otp <= $random(seed);
        do_reset(1'h0, 2'($random(seed)));
        chk(8'(hw), 8'h00);
        chk(act, otp[7:0]);
        rd_chk(8'h13, 8'h00);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            wr(regs[i], d);
            rd_chk(regs[i], d & msk[i]);
        end
        chk(8'(trim), d & 8'h3F);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h00, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(8'h13, 8'(s << 1));
            wr(8'h14, 8'h00);
            ref_chk(1'h1, exp_en(1'h1, 1'(s)));
            ref_chk(1'h0, exp_en(1'h0, 1'(s)));
        end
        ref_chk(1'h1, exp_en(1'h1, 1'h1));
        wr(8'h14, 8'h02);
        ref_chk(1'h0, exp_en(1'h1, 1'h1));
        for (int s = 0; s < 4; s++) begin
            do_reset(1'h1, 2'(s));
            chk(8'(hw), 8'h01);
            chk(8'(idx), 8'(s));
            chk(act, otp[8*s +: 8]);
            chk(8'(busy), 8'h01);
            rd_chk(8'h04, 8'(8'h08 + s));
            rd_chk(8'(8'h20 + 4 * s), otp[8*s +: 8]);
            wr(8'h18, 8'h3F);
            rd_chk(8'h18, 8'h00);
            rd_chk(8'h00, 8'h03);
        end
        test_done();
    end
endmodule
